// File: src/mcom_top.sv
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "mcom_params.svh"

module mcom_top (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Motor events, same clock
  input  wire logic        commutation_event,
  input  wire logic        demag_event,
  input  wire logic        zero_cross_event,
  // Asynchronous inputs
  input  wire logic        comparator_out,
  input  wire logic        emergency_stop_pin_n,
  input  wire logic [1:0]  reset_state_option,
  // Analog routing and timer control
  output logic             amplifier_enable,
  output logic             comparator_input_select,
  output logic             delay_timer_clk_en,
  output logic             dz_event_enable,
  // Motor outputs
  output logic [5:0]       motor_output_pins,
  output logic [5:0]       motor_output_pins_oe_n
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic       cmp_s1, cmp_s2, em_s1, em_s2;
  logic [1:0] opt_s1, opt_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      em_s1  <= 1'b1;
      em_s2  <= 1'b1;
      opt_s1 <= `MCOM_OPT_HIZ;
      opt_s2 <= `MCOM_OPT_HIZ;
    end else begin
      cmp_s1 <= comparator_out;
      cmp_s2 <= cmp_s1;
      em_s1  <= emergency_stop_pin_n;
      em_s2  <= em_s1;
      opt_s1 <= reset_state_option;
      opt_s2 <= opt_s1;
    end
  end

  // ----------------------------------------------------------------
  // Register file and APB slave
  // ----------------------------------------------------------------
  logic                moe_reg, moe_next, dac_reg, dac_next, cke_reg, cke_next;
  logic [2:0]          os_reg, os_next;
  logic                os2_act_reg, os2_act_next;
  logic                csel_reg, csel_next, ampen_reg, ampen_next;
  logic [3:0]          freq_reg, freq_next, off_reg, off_next, ds_reg, ds_next;
  logic                sensor_reg, sensor_next, on_time_sampling_flag_reg, on_time_sampling_flag_next;
  mcom_pkg::mcom_chan_t preload_reg, preload_next, phase_reg, phase_next;
  mcom_pkg::mcom_chan_t pol_reg, pol_next, grp_reg, grp_next;
  mcom_pkg::mcom_step_t step_reg, step_next;
  logic [31:0]         prdata_next;
  logic                pready_next, pslverr_next;
  logic                tclk_next, dz_next;
  logic                wr_en, mapped, c_evt;

  mcom_win_if win ();

  always_comb begin
    wr_en = psel && penable && pready && pwrite;
    unique case (paddr)
      `MCOM_ADDR_CTRL_A, `MCOM_ADDR_CTRL_B, `MCOM_ADDR_REF, `MCOM_ADDR_PRESCALER,
      `MCOM_ADDR_PWM_CTRL, `MCOM_ADDR_CTRL_C, `MCOM_ADDR_PHASE, `MCOM_ADDR_POLARITY,
      `MCOM_ADDR_GROUP, `MCOM_ADDR_STATUS: mapped = 1'b1;
      default:                             mapped = 1'b0;
    endcase
    moe_next     = moe_reg;
    dac_next     = dac_reg;
    cke_next     = cke_reg;
    os_next      = os_reg;
    csel_next    = csel_reg;
    ampen_next   = ampen_reg;
    freq_next    = freq_reg;
    off_next     = off_reg;
    ds_next      = ds_reg;
    sensor_next  = sensor_reg;
    on_time_sampling_flag_next    = on_time_sampling_flag_reg;
    preload_next = preload_reg;
    pol_next     = pol_reg;
    grp_next     = grp_reg;
    c_evt        = commutation_event;
    if (wr_en) begin
      unique case (paddr)
        `MCOM_ADDR_CTRL_A: begin
          moe_next = pwdata[`MCOM_A_MOE_BIT];
          dac_next = pwdata[`MCOM_A_DAC_BIT];
          cke_next = pwdata[`MCOM_A_CKE_BIT];
        end
        `MCOM_ADDR_CTRL_B:    os_next = pwdata[2:0];
        `MCOM_ADDR_REF: begin
          csel_next  = pwdata[`MCOM_REF_CSEL_BIT];
          ampen_next = pwdata[`MCOM_REF_AMPEN_BIT];
        end
        `MCOM_ADDR_PRESCALER: freq_next = pwdata[3:0];
        `MCOM_ADDR_PWM_CTRL:  off_next  = pwdata[3:0];
        `MCOM_ADDR_CTRL_C: begin
          sensor_next = pwdata[`MCOM_C_SENSOR_BIT];
          on_time_sampling_flag_next   = pwdata[`MCOM_C_ON_TIME_SAMPLING_FLAG_BIT];
          ds_next     = pwdata[`MCOM_C_DS_LSB +: 4];
        end
        `MCOM_ADDR_PHASE: begin
          preload_next = pwdata[5:0];
          if (dac_reg) c_evt = 1'b1;
        end
        `MCOM_ADDR_POLARITY:  pol_next = pwdata[5:0];
        `MCOM_ADDR_GROUP:     grp_next = pwdata[5:0];
        default: ;
      endcase
    end
    // Emergency clear wins over a software write of the enable
    if (!em_s2) moe_next = 1'b0;
    // Preload is transparent on a direct write so the new value lands now
    phase_next   = c_evt ? preload_next : phase_reg;
    os2_act_next = c_evt ? os_next[2] : os2_act_reg;
    step_next    = step_reg;
    if (dac_reg) begin
      step_next = mcom_pkg::STEP_RUN;
    end else if (c_evt) begin
      step_next = mcom_pkg::STEP_DEMAG;
    end else if (demag_event && step_reg == mcom_pkg::STEP_DEMAG) begin
      step_next = mcom_pkg::STEP_BEMF;
    end else if (zero_cross_event && step_reg == mcom_pkg::STEP_BEMF) begin
      step_next = mcom_pkg::STEP_RUN;
    end
    tclk_next = cke_next && !dac_next;
    dz_next   = !dac_next;
    pready_next  = psel && !penable;
    pslverr_next = psel && !penable && !mapped;
    prdata_next  = 32'h0000_0000;
    if (psel && !penable) begin
      unique case (paddr)
        `MCOM_ADDR_CTRL_A:    prdata_next = {29'h0, cke_reg, dac_reg, moe_reg};
        `MCOM_ADDR_CTRL_B:    prdata_next = {29'h0, os_reg};
        `MCOM_ADDR_REF:       prdata_next = {30'h0, ampen_reg, csel_reg};
        `MCOM_ADDR_PRESCALER: prdata_next = {28'h0, freq_reg};
        `MCOM_ADDR_PWM_CTRL:  prdata_next = {28'h0, off_reg};
        `MCOM_ADDR_CTRL_C:    prdata_next = {24'h0, ds_reg, 2'b00, on_time_sampling_flag_reg, sensor_reg};
        `MCOM_ADDR_PHASE:     prdata_next = {18'h0, phase_reg, 2'b00, preload_reg};
        `MCOM_ADDR_POLARITY:  prdata_next = {26'h0, pol_reg};
        `MCOM_ADDR_GROUP:     prdata_next = {26'h0, grp_reg};
        `MCOM_ADDR_STATUS:    prdata_next = {18'h0, motor_output_pins, 5'h00, dac_reg,
                                             !em_s2, win.pwm_on};
        default:              prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      moe_reg     <= 1'b0;
      dac_reg     <= 1'b0;
      cke_reg     <= 1'b0;
      os_reg      <= 3'h0;
      os2_act_reg <= 1'b0;
      csel_reg    <= 1'b0;
      ampen_reg   <= 1'b0;
      freq_reg    <= 4'h0;
      off_reg     <= 4'h0;
      ds_reg      <= 4'h0;
      sensor_reg  <= 1'b0;
      on_time_sampling_flag_reg    <= 1'b0;
      preload_reg <= 6'h00;
      phase_reg   <= 6'h00;
      pol_reg     <= 6'h00;
      grp_reg     <= 6'h00;
      step_reg    <= mcom_pkg::STEP_DEMAG;
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      delay_timer_clk_en      <= 1'b0;
      dz_event_enable         <= 1'b1;
      amplifier_enable        <= 1'b0;
      comparator_input_select <= 1'b0;
    end else begin
      moe_reg     <= moe_next;
      dac_reg     <= dac_next;
      cke_reg     <= cke_next;
      os_reg      <= os_next;
      os2_act_reg <= os2_act_next;
      csel_reg    <= csel_next;
      ampen_reg   <= ampen_next;
      freq_reg    <= freq_next;
      off_reg     <= off_next;
      ds_reg      <= ds_next;
      sensor_reg  <= sensor_next;
      on_time_sampling_flag_reg    <= on_time_sampling_flag_next;
      preload_reg <= preload_next;
      phase_reg   <= phase_next;
      pol_reg     <= pol_next;
      grp_reg     <= grp_next;
      step_reg    <= step_next;
      prdata      <= prdata_next;
      pready      <= pready_next;
      pslverr     <= pslverr_next;
      delay_timer_clk_en      <= tclk_next;
      dz_event_enable         <= dz_next;
      amplifier_enable        <= ampen_next;
      comparator_input_select <= csel_next;
    end
  end

  // ----------------------------------------------------------------
  // Measurement window generator
  // ----------------------------------------------------------------
  assign win.freq_sel = freq_reg;
  assign win.off_sel  = off_reg;
  assign win.zero_off = sensor_reg || on_time_sampling_flag_reg || (ds_reg != 4'h0);
  assign win.cmp_high = cmp_s2;

  mcom_window_gen u_window (
    .pclk    (pclk),
    .presetn (presetn),
    .win     (win.gen)
  );

  // ----------------------------------------------------------------
  // Channel manager output stage
  // ----------------------------------------------------------------
  logic       pwm_low_grp;
  logic       out_force_n;
  logic [5:0] pin_next, oe_n_next;

  always_comb begin
    unique case (step_reg)
      mcom_pkg::STEP_DEMAG: pwm_low_grp = os2_act_reg;
      mcom_pkg::STEP_BEMF:  pwm_low_grp = os_reg[1];
      mcom_pkg::STEP_RUN:   pwm_low_grp = os_reg[0];
      default:              pwm_low_grp = os_reg[0];
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_chan
      logic on_lvl;
      // PWM gates only outputs in the group that the step selects
      assign on_lvl = phase_reg[gi] &&
                      ((grp_reg[gi] != pwm_low_grp) || win.pwm_on);
      always_comb begin
        if (!moe_reg || !em_s2) begin
          oe_n_next[gi] = (opt_s2 == `MCOM_OPT_HIZ);
          pin_next[gi]  = (opt_s2 == `MCOM_OPT_HIGH);
        end else begin
          oe_n_next[gi] = 1'b0;
          pin_next[gi]  = pol_reg[gi] ? on_lvl : !on_lvl;
        end
      end
    end
  endgenerate

  // Emergency reaches the pins with no clock; hi-Z is the only safe constant
  assign out_force_n = presetn && emergency_stop_pin_n;

  always_ff @(posedge pclk or negedge out_force_n) begin
    if (!out_force_n) begin
      motor_output_pins      <= 6'h00;
      motor_output_pins_oe_n <= 6'h3F;
    end else begin
      motor_output_pins      <= pin_next;
      motor_output_pins_oe_n <= oe_n_next;
    end
  end

endmodule : mcom_top

// File: src/mcom_params.svh
`ifndef MCOM_PARAMS_SVH
`define MCOM_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MCOM_ADDR_CTRL_A      8'h00
`define MCOM_ADDR_CTRL_B      8'h04
`define MCOM_ADDR_REF         8'h08
`define MCOM_ADDR_PRESCALER   8'h0C
`define MCOM_ADDR_PWM_CTRL    8'h10
`define MCOM_ADDR_CTRL_C      8'h14
`define MCOM_ADDR_PHASE       8'h18
`define MCOM_ADDR_POLARITY    8'h1C
`define MCOM_ADDR_GROUP       8'h20
`define MCOM_ADDR_STATUS      8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MCOM_A_MOE_BIT        0
`define MCOM_A_DAC_BIT        1
`define MCOM_A_CKE_BIT        2
`define MCOM_REF_CSEL_BIT     0
`define MCOM_REF_AMPEN_BIT    1
`define MCOM_C_SENSOR_BIT     0
`define MCOM_C_ON_TIME_SAMPLING_FLAG_BIT       1
`define MCOM_C_DS_LSB         4
`define MCOM_PH_ACT_LSB       8
`define MCOM_ST_PWM_BIT       0
`define MCOM_ST_EMERG_BIT     1
`define MCOM_ST_DAC_BIT       2
`define MCOM_ST_PINS_LSB      8

// ----------------------------------------------------------------
// Reset values and output reset-state option codes
// ----------------------------------------------------------------
`define MCOM_RST_BYTE         8'h00
`define MCOM_OPT_HIZ          2'h0
`define MCOM_OPT_LOW          2'h1
`define MCOM_OPT_HIGH         2'h2

// ----------------------------------------------------------------
// Timing, counted in peripheral clock cycles at the reference rate
// ----------------------------------------------------------------
`define MCOM_REF_CLK_HZ       4000000
`define MCOM_OFF_STEP_NS      2500
`define MCOM_OFF_STEP_CYC     ((`MCOM_OFF_STEP_NS * (`MCOM_REF_CLK_HZ / 1000000)) / 1000)
`define MCOM_WIN_TICK_DIV     4
// Window period in ticks of WIN_TICK_DIV cycles, code 15 first
`define MCOM_WIN_TICKS_TABLE  {12'hA04, 12'h640, 12'h410, 12'h320, 12'h280, 12'h140, \
                               12'h0A0, 12'h064, 12'h050, 12'h041, 12'h037, 12'h032, \
                               12'h028, 12'h01E, 12'h019, 12'h014}

`endif

// File: src/mcom_pkg.sv
package mcom_pkg;

  // Commutation step: C..D, D..Z, Z..C
  typedef enum logic [1:0] {
    STEP_DEMAG,
    STEP_BEMF,
    STEP_RUN
  } mcom_step_t;

  typedef logic [5:0] mcom_chan_t;

endpackage : mcom_pkg

// File: src/mcom_win_if.sv
`timescale 1ns/1ps

interface mcom_win_if;
  logic [3:0] freq_sel;
  logic [3:0] off_sel;
  logic       zero_off;
  logic       cmp_high;
  logic       pwm_on;
  logic       window_start;

  modport gen  (input freq_sel, off_sel, zero_off, cmp_high, output pwm_on, window_start);
  modport ctrl (output freq_sel, off_sel, zero_off, cmp_high, input pwm_on, window_start);
endinterface : mcom_win_if

// File: src/mcom_window_gen.sv
`timescale 1ns/1ps
`include "mcom_params.svh"

module mcom_window_gen #(
  parameter int TICK_DIV = `MCOM_WIN_TICK_DIV,
  parameter int OFF_STEP = `MCOM_OFF_STEP_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control and result
  mcom_win_if.gen  win
);

  localparam logic [191:0] PERIOD_TABLE = `MCOM_WIN_TICKS_TABLE;

  logic [3:0]  tick_reg, tick_next;
  logic [11:0] per_reg, per_next;
  logic [7:0]  off_reg, off_next;
  logic        open_reg, open_next;
  logic        pwm_reg, pwm_next;
  logic        start_reg, start_next;
  logic [11:0] period_ticks;
  logic [13:0] period_cyc;
  logic [7:0]  off_cyc;
  logic        tick_end;
  logic        per_end;

  // ----------------------------------------------------------------
  // Measurement window and PWM on/off
  // ----------------------------------------------------------------
  always_comb begin
    period_ticks = PERIOD_TABLE[win.freq_sel*12 +: 12];
    period_cyc   = 14'(32'(period_ticks) * TICK_DIV);
    off_cyc      = 8'((32'(win.off_sel) + 32'd1) * OFF_STEP);
    tick_end     = (tick_reg == 4'(TICK_DIV - 1));
    per_end      = tick_end && (per_reg >= period_ticks - 12'h001);
    tick_next    = tick_end ? 4'h0 : tick_reg + 4'h1;
    per_next     = !tick_end ? per_reg : (per_end ? 12'h000 : per_reg + 12'h001);
    start_next   = per_end;
    off_next     = off_reg;
    open_next    = open_reg;
    pwm_next     = pwm_reg;
    if (!win.zero_off && {6'h00, off_cyc} >= period_cyc) begin
      // Off window not shorter than the period: output held on
      pwm_next  = 1'b1;
      open_next = 1'b0;
    end else if (per_end) begin
      off_next  = 8'h00;
      open_next = !win.zero_off;
      pwm_next  = win.zero_off && !win.cmp_high;
    end else if (open_reg) begin
      off_next = off_reg + 8'h01;
      if (off_reg + 8'h01 >= off_cyc) begin
        open_next = 1'b0;
        pwm_next  = !win.cmp_high;
      end
    end else if (win.cmp_high) begin
      // Comparator trip stretches the off time past the minimum
      pwm_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg  <= 4'h0;
      per_reg   <= 12'h000;
      off_reg   <= 8'h00;
      open_reg  <= 1'b0;
      pwm_reg   <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      tick_reg  <= tick_next;
      per_reg   <= per_next;
      off_reg   <= off_next;
      open_reg  <= open_next;
      pwm_reg   <= pwm_next;
      start_reg <= start_next;
    end
  end

  assign win.pwm_on       = pwm_reg;
  assign win.window_start = start_reg;

endmodule : mcom_window_gen

// File: sim/mcom_top_checker.sv
`timescale 1ns/1ps

module mcom_top_checker (
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and control outputs
  input wire logic        emergency_stop_pin_n,
  input wire logic [1:0]  reset_state_option,
  input wire logic        amplifier_enable,
  input wire logic        comparator_input_select,
  input wire logic        delay_timer_clk_en,
  input wire logic        dz_event_enable,
  input wire logic [5:0]  motor_output_pins,
  input wire logic [5:0]  motor_output_pins_oe_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire logic wr_done = psel && penable && pready && pwrite;
  wire logic wr_ctl  = wr_done && (paddr == 8'h00);
  wire logic wr_ref  = wr_done && (paddr == 8'h08);
  // Option code 3 drives low like code 1
  wire logic rst_ok  = (reset_state_option == 2'h0) ? (motor_output_pins_oe_n == 6'h3F) :
    ((motor_output_pins_oe_n == 6'h00) &&
     (motor_output_pins == ((reset_state_option == 2'h2) ? 6'h3F : 6'h00)));

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_emerg_release;
    (!emergency_stop_pin_n) [*4] ##1 emergency_stop_pin_n;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_setup_ready: assert property (s_setup |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");
  a_unmapped_err: assert property (s_setup and (paddr > 8'h24) |=> pslverr)
    else $error("no error on unmapped address");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside access");
  a_select_follow: assert property (wr_ref |=> comparator_input_select == $past(pwdata[0]))
    else $error("comparator select differs from write");
  a_amp_follow: assert property (wr_ref |=> amplifier_enable == $past(pwdata[1]))
    else $error("amplifier enable differs from write");
  a_direct_stops_timer: assert property (wr_ctl && pwdata[1] |-> ##[1:2]
    (!delay_timer_clk_en && !dz_event_enable))
    else $error("timer or events still enabled in direct access");
  a_timer_runs: assert property (wr_ctl && pwdata[2:1] == 2'b10 |-> ##[1:2]
    (delay_timer_clk_en && dz_event_enable))
    else $error("timer clock not enabled");
  a_emerg_hiz: assert property (!emergency_stop_pin_n |-> motor_output_pins_oe_n == 6'h3F)
    else $error("outputs driven during emergency");
  a_emerg_latched: assert property (s_emerg_release |-> ##2 rst_ok)
    else $error("outputs left reset state after emergency");
  a_disable_state: assert property (wr_ctl && !pwdata[0] && emergency_stop_pin_n
    |-> ##3 rst_ok)
    else $error("outputs not in reset state after disable");
endmodule : mcom_top_checker

bind mcom_top mcom_top_checker u_mcom_top_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .emergency_stop_pin_n(emergency_stop_pin_n), .reset_state_option(reset_state_option),
  .amplifier_enable(amplifier_enable), .comparator_input_select(comparator_input_select),
  .delay_timer_clk_en(delay_timer_clk_en), .dz_event_enable(dz_event_enable),
  .motor_output_pins(motor_output_pins), .motor_output_pins_oe_n(motor_output_pins_oe_n)
);

// File: sim/mcom_gate_driver_model.sv
`timescale 1ns/1ps

module mcom_gate_driver_model (
  // Bench commands
  input  wire logic       overcurrent,
  input  wire logic       driver_fault,
  // Inverter side
  input  wire logic [5:0] motor_output_pins,
  input  wire logic [5:0] motor_output_pins_oe_n,
  output logic            comparator_out,
  output logic            emergency_stop_pin_n,
  output logic [5:0]      gate_level
);
  // Shunt comparator settles off the clock grid
  initial comparator_out = 1'b0;
  always @(overcurrent) comparator_out <= #37 overcurrent;
  // Alarm line is open drain with a pull-up
  initial emergency_stop_pin_n = 1'b1;
  always @(driver_fault) emergency_stop_pin_n <= #40 !driver_fault;
  // Released gate inputs fall to the driver pull-down
  assign gate_level = motor_output_pins & ~motor_output_pins_oe_n;
endmodule : mcom_gate_driver_model

// File: sim/mcom_top_test.sv
`timescale 1ns/1ps
`include "mcom_params.svh"

module mcom_top_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        overcurrent, driver_fault, comparator_out, emergency_stop_pin_n;
  logic        amplifier_enable, comparator_input_select, delay_timer_clk_en, dz_event_enable;
  logic [2:0]  ev;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  reset_state_option;
  logic [5:0]  pins, oe_n, gate;
  logic [16:0] rows [9];
  int          fail_count, checks, cyc, per, offc, lows, expv;
  localparam logic [191:0] WIN_TICKS = `MCOM_WIN_TICKS_TABLE;
  mcom_top u_mcom_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .commutation_event(ev[0]), .demag_event(ev[1]), .zero_cross_event(ev[2]),
    .comparator_out(comparator_out), .emergency_stop_pin_n(emergency_stop_pin_n),
    .reset_state_option(reset_state_option), .amplifier_enable(amplifier_enable),
    .comparator_input_select(comparator_input_select),
    .delay_timer_clk_en(delay_timer_clk_en), .dz_event_enable(dz_event_enable),
    .motor_output_pins(pins), .motor_output_pins_oe_n(oe_n));

  mcom_gate_driver_model u_mcom_gate_driver_model (
    .overcurrent(overcurrent), .driver_fault(driver_fault), .motor_output_pins(pins),
    .motor_output_pins_oe_n(oe_n), .comparator_out(comparator_out),
    .emergency_stop_pin_n(emergency_stop_pin_n), .gate_level(gate));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Two idle cycles between back-to-back transfers keep each signal to one assignment per step
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("access cycles", 32'h1, n);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rdchk

  task pulse(input logic [2:0] e);
    @(posedge pclk);
    ev <= e;
    @(posedge pclk);
    ev <= 3'h0;
  endtask : pulse

  task finish_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // Longest code holds three windows of 10256 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, overcurrent, driver_fault} = 6'h00;
    {ev, paddr, pwdata, reset_state_option} = '0;
    // Rows: cmp, window code, off code, sampling config
    rows = '{{1'b0, 4'h0, 4'h0, 8'h00}, {1'b0, 4'h3, 4'h1, 8'h00}, {1'b0, 4'h1, 4'h3, 8'h00},
             {1'b0, 4'h0, 4'hF, 8'h00}, {1'b1, 4'h0, 4'h0, 8'h00}, {1'b0, 4'h0, 4'h0, 8'h01},
             {1'b0, 4'h0, 4'h3, 8'h02}, {1'b0, 4'h0, 4'h3, 8'h10}, {1'b0, 4'hF, 4'h0, 8'h00}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int o = 0; o < 4; o++) begin
      reset_state_option <= o[1:0];
      repeat (5) @(posedge pclk);
      chk("reset oe_n", (o == 0) ? 32'h3F : 32'h0, {26'h0, oe_n});
      chk("reset pins", (o == 2) ? 32'h3F : 32'h0, {26'h0, pins});
    end
    reset_state_option <= 2'h0;
    rdchk("phase after reset", `MCOM_ADDR_PHASE, 32'h0);
    chk("dz enable after reset", 32'h1, {31'h0, dz_event_enable});
    $display("test reset done");

    for (int v = 0; v < 4; v++) begin
      apb(1'b1, `MCOM_ADDR_REF, v);
      chk("select", v & 1, {31'h0, comparator_input_select});
      chk("amp enable", v >> 1, {31'h0, amplifier_enable});
      rdchk("ref readback", `MCOM_ADDR_REF, v);
    end
    apb(1'b1, `MCOM_ADDR_REF, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped read err", 32'h1, {31'h0, err});
    chk("unmapped read data", 32'h0, rd);
    apb(1'b1, 8'h44, 32'hFF);
    chk("unmapped write err", 32'h1, {31'h0, err});
    $display("test registers done");

    apb(1'b1, `MCOM_ADDR_CTRL_B, 32'h7);
    apb(1'b1, `MCOM_ADDR_POLARITY, 32'h0F);
    apb(1'b1, `MCOM_ADDR_CTRL_A, 32'h5);
    apb(1'b1, `MCOM_ADDR_PHASE, 32'h33);
    repeat (4) @(posedge pclk);
    chk("timer clock", 32'h1, {31'h0, delay_timer_clk_en});
    chk("pins before event", 32'h30, {26'h0, pins});
    rdchk("phase preload", `MCOM_ADDR_PHASE, 32'h0033);
    pulse(3'h1);
    repeat (3) @(posedge pclk);
    chk("pins after event", 32'h03, {26'h0, pins});
    chk("oe_n running", 32'h0, {26'h0, oe_n});
    rdchk("phase active", `MCOM_ADDR_PHASE, 32'h3333);
    pulse(3'h2);
    pulse(3'h4);
    repeat (3) @(posedge pclk);
    chk("pins through steps", 32'h03, {26'h0, pins});
    $display("test commutation done");

    overcurrent <= 1'b1;
    apb(1'b1, `MCOM_ADDR_CTRL_C, 32'h1);
    apb(1'b1, `MCOM_ADDR_CTRL_B, 32'h0);
    apb(1'b1, `MCOM_ADDR_GROUP, 32'h2A);
    apb(1'b1, `MCOM_ADDR_POLARITY, 32'h3F);
    apb(1'b1, `MCOM_ADDR_CTRL_A, 32'h7);
    chk("timer in direct", 32'h0, {31'h0, delay_timer_clk_en});
    chk("events in direct", 32'h0, {31'h0, dz_event_enable});
    apb(1'b1, `MCOM_ADDR_PHASE, 32'h3F);
    repeat (100) @(posedge pclk);
    chk("direct pwm off", 32'h2A, {26'h0, pins});
    rdchk("status direct", `MCOM_ADDR_STATUS, 32'h2A04);
    overcurrent <= 1'b0;
    repeat (100) @(posedge pclk);
    chk("direct pwm on", 32'h3F, {26'h0, pins});
    overcurrent <= 1'b1;
    apb(1'b1, `MCOM_ADDR_CTRL_B, 32'h1);
    repeat (100) @(posedge pclk);
    chk("low group pwm", 32'h15, {26'h0, pins});
    overcurrent <= 1'b0;
    $display("test direct access done");

    apb(1'b1, `MCOM_ADDR_CTRL_B, 32'h0);
    apb(1'b1, `MCOM_ADDR_GROUP, 32'h0);
    apb(1'b1, `MCOM_ADDR_PHASE, 32'h01);
    foreach (rows[i]) begin
      per  = WIN_TICKS[rows[i][15:12] * 12 +: 12] * `MCOM_WIN_TICK_DIV;
      offc = (rows[i][11:8] + 1) * `MCOM_OFF_STEP_CYC;
      expv = rows[i][16] ? 2 * per : (rows[i][7:0] != 8'h0 || offc >= per) ? 0 : 2 * offc;
      overcurrent <= rows[i][16];
      apb(1'b1, `MCOM_ADDR_PRESCALER, rows[i][15:12]);
      apb(1'b1, `MCOM_ADDR_PWM_CTRL, rows[i][11:8]);
      apb(1'b1, `MCOM_ADDR_CTRL_C, rows[i][7:0]);
      repeat (per + 40) @(posedge pclk);
      lows = 0;
      repeat (2 * per) begin
        @(posedge pclk);
        if (pins[0] === 1'b0) lows++;
      end
      chk("pwm low cycles", expv, lows);
    end
    overcurrent <= 1'b0;
    $display("test window done");

    apb(1'b1, `MCOM_ADDR_CTRL_C, 32'h1);
    apb(1'b1, `MCOM_ADDR_CTRL_B, 32'h1);
    apb(1'b1, `MCOM_ADDR_PHASE, 32'h3F);
    reset_state_option <= 2'h1;
    repeat (6) @(posedge pclk);
    chk("pins before fault", 32'h3F, {26'h0, pins});
    driver_fault <= 1'b1;
    #70;
    chk("oe_n on fault", 32'h3F, {26'h0, oe_n});
    chk("gates on fault", 32'h0, {26'h0, gate});
    repeat (6) @(posedge pclk);
    driver_fault <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("pins after fault", 32'h0, {26'h0, pins});
    chk("oe_n after fault", 32'h0, {26'h0, oe_n});
    rdchk("enable cleared", `MCOM_ADDR_CTRL_A, 32'h6);
    apb(1'b1, `MCOM_ADDR_CTRL_A, 32'h7);
    repeat (4) @(posedge pclk);
    chk("pins re-enabled", 32'h3F, {26'h0, pins});
    apb(1'b1, `MCOM_ADDR_CTRL_A, 32'h6);
    repeat (4) @(posedge pclk);
    chk("pins disabled", 32'h0, {26'h0, pins});
    chk("oe_n disabled", 32'h0, {26'h0, oe_n});
    $display("test emergency done");
    finish_test();
  end
endmodule : mcom_top_test
